//--- verilog/rsx_exec.v
`timescale 1ns/10ps
// Overview of operation
// - Rotate right through carry on addressed file register; old bit 0 goes to carry.
// - Destination zero writes accumulator; destination one writes file register back.
// - Rotate left through carry; old bit 7 into carry; one cycle.
// - Sleep instruction clears power-down flag and sets time-out flag.
// - Sleep instruction clears the watchdog counter and its prescaler.
// - After sleep, oscillator halts and execution stops until wake-up.
// - Literal minus accumulator, eight bit two's complement, result to accumulator.
module rsx_exec (
  input wire sys_clk,
  input wire rst_b,
  input wire op_valid,
  input wire [2:0] op_sel,
  input wire [6:0] file_addr,
  input wire dest_sel,
  input wire [7:0] literal_val,
  input wire wdt_tick,
  input wire wake_req,
  output reg [7:0] acc_q,
  output reg carry_q,
  output reg dc_q,
  output reg zero_q,
  output reg sleep_entry_flag_n_q,
  output reg expiry_status_n_q,
  output reg [7:0] watchdog_counter_q,
  output reg [7:0] prescale_q,
  output reg osc_run_q,
  output wire exec_ready,
  output reg [7:0] file_rd_data_q
);
`include "rsx_defs.vh"

  reg [7:0] file_mem [0:127];
  reg wake_s1_q;
  reg wake_s2_q;
  reg wake_s3_q;
  wire [7:0] alu_src;
  wire [7:0] alu_res;
  wire alu_c;
  wire alu_dc;
  wire alu_z;
  wire do_op;
  wire is_rot;
  wire is_sleep;

  // Rotate decode, used only by file register writeback
  function is_rot_op;
    input [2:0] sel;
    begin
      is_rot_op = (sel == `RSX_OP_RRC) || (sel == `RSX_OP_RLC);
    end
  endfunction

  // Sleep decode, used only by watchdog clear
  function is_sleep_op;
    input [2:0] sel;
    begin
      is_sleep_op = (sel == `RSX_OP_SLEEP);
    end
  endfunction

  // Execution proceeds only while the oscillator runs
  assign exec_ready = osc_run_q;
  assign do_op = op_valid & osc_run_q;
  assign is_rot = is_rot_op(op_sel);
  assign is_sleep = is_sleep_op(op_sel);
  assign alu_src = (op_sel == `RSX_OP_LMA) ? literal_val : file_mem[file_addr];

  rsx_alu u_alu (
    .op_sel(op_sel),
    .src_val(alu_src),
    .acc_val(acc_q),
    .carry_in(carry_q),
    .result(alu_res),
    .carry_out(alu_c),
    .dc_out(alu_dc),
    .zero_out(alu_z)
  );

  // File register writeback, no reset on storage
  always @(posedge sys_clk) begin
    if (do_op && is_rot && dest_sel == `RSX_DEST_FILE) begin
      file_mem[file_addr] <= alu_res;
    end
    file_rd_data_q <= file_mem[file_addr];
  end

  // Wake request synchroniser, three stages
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wake_s1_q <= 1'b0;
      wake_s2_q <= 1'b0;
      wake_s3_q <= 1'b0;
    end else begin
      wake_s1_q <= wake_req;
      wake_s2_q <= wake_s1_q;
      wake_s3_q <= wake_s2_q;
    end
  end

  // Accumulator and status flags
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_q <= `RSX_ACC_RST;
      carry_q <= `RSX_CARRY_RST;
      dc_q <= `RSX_DC_RST;
      zero_q <= `RSX_ZERO_RST;
      sleep_entry_flag_n_q <= `RSX_PD_N_RST;
      expiry_status_n_q <= `RSX_TO_N_RST;
      osc_run_q <= 1'b1;
    end else if (do_op) begin
      case (op_sel)
        `RSX_OP_RRC, `RSX_OP_RLC: begin
          carry_q <= alu_c;
          if (dest_sel == `RSX_DEST_ACC) begin
            acc_q <= alu_res;
          end
        end
        `RSX_OP_LMA: begin
          acc_q <= alu_res;
          carry_q <= alu_c;
          dc_q <= alu_dc;
          zero_q <= alu_z;
        end
        `RSX_OP_SLEEP: begin
          sleep_entry_flag_n_q <= 1'b0;
          expiry_status_n_q <= 1'b1;
          osc_run_q <= 1'b0;
        end
        default: begin
          acc_q <= acc_q;
        end
      endcase
    end else if (!osc_run_q && wake_s2_q && wake_s3_q) begin
      osc_run_q <= 1'b1;
    end
  end

  // Watchdog counter and prescaler; frozen while asleep
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      watchdog_counter_q <= `RSX_WDT_CLR;
      prescale_q <= `RSX_PRE_CLR;
    end else if (do_op && is_sleep) begin
      watchdog_counter_q <= `RSX_WDT_CLR;
      prescale_q <= `RSX_PRE_CLR;
    end else if (wdt_tick && osc_run_q) begin
      prescale_q <= prescale_q + 8'h01;
      if (prescale_q == 8'hFF) begin
        watchdog_counter_q <= watchdog_counter_q + 8'h01;
      end
    end
  end
endmodule // rsx_exec

//--- verilog/rsx_defs.vh
`ifndef RSX_DEFS_VH
`define RSX_DEFS_VH
// Operation codes presented on op_sel
`define RSX_OP_NONE 3'h0
`define RSX_OP_RRC 3'h1
`define RSX_OP_RLC 3'h2
`define RSX_OP_LMA 3'h3
`define RSX_OP_SLEEP 3'h4
// Widths and ranges
`define RSX_DATA_W 8
`define RSX_ADDR_W 7
`define RSX_FILE_DEPTH 128
// Reset values
`define RSX_ACC_RST 8'h00
`define RSX_CARRY_RST 1'b0
`define RSX_DC_RST 1'b0
`define RSX_ZERO_RST 1'b0
`define RSX_PD_N_RST 1'b1
`define RSX_TO_N_RST 1'b1
`define RSX_WDT_CLR 8'h00
`define RSX_PRE_CLR 8'h00
// Destination select
`define RSX_DEST_ACC 1'b0
`define RSX_DEST_FILE 1'b1
`endif

//--- verilog/rsx_alu.v
`timescale 1ns/10ps
// Combinational result and flag generation for the rotate and subtract paths
module rsx_alu (
  input wire [2:0] op_sel,
  input wire [7:0] src_val,
  input wire [7:0] acc_val,
  input wire carry_in,
  output reg [7:0] result,
  output reg carry_out,
  output reg dc_out,
  output reg zero_out
);
`include "rsx_defs.vh"

  reg [8:0] diff;
  reg [4:0] ldiff;

  // Select operation and derive flags
  always @* begin
    diff = {1'b0, src_val} - {1'b0, acc_val};
    ldiff = {1'b0, src_val[3:0]} - {1'b0, acc_val[3:0]};
    result = src_val;
    carry_out = carry_in;
    dc_out = 1'b0;
    zero_out = 1'b0;
    case (op_sel)
      `RSX_OP_RRC: begin
        result = {carry_in, src_val[7:1]};
        carry_out = src_val[0];
      end
      `RSX_OP_RLC: begin
        result = {src_val[6:0], carry_in};
        carry_out = src_val[7];
      end
      `RSX_OP_LMA: begin
        result = diff[7:0];
        carry_out = ~diff[8];
        dc_out = ~ldiff[4];
        zero_out = (diff[7:0] == 8'h00);
      end
      default: begin
        result = src_val;
      end
    endcase
  end
endmodule // rsx_alu

//--- tb/rsx_exec_chk.sv
`timescale 1ns/10ps
module rsx_exec_chk (input wire sys_clk, rst_b, op_valid, dest_sel, wdt_tick, wake_req,
  input wire [2:0] op_sel, input wire [6:0] file_addr, input wire [7:0] literal_val,
  input wire [7:0] acc_q, file_rd_data_q, watchdog_counter_q, prescale_q,
  input wire carry_q, dc_q, zero_q, sleep_entry_flag_n_q, expiry_status_n_q, osc_run_q,
  input wire exec_ready);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // Operation taken at this edge
  wire go = op_valid && exec_ready;
  AST_RRC: assert property (
    go && op_sel == 3'h1 && !dest_sel && $stable(file_addr) && !$past(go)
    |=> {acc_q, carry_q} == {$past(carry_q), $past(file_rd_data_q)}) else $error("rrc bad");
  AST_RLC: assert property (
    go && op_sel == 3'h2 && !dest_sel && $stable(file_addr) && !$past(go)
    |=> {carry_q, acc_q} == {$past(file_rd_data_q), $past(carry_q)}) else $error("rlc bad");
  AST_DEST: assert property (
    go && dest_sel && op_sel inside {3'h1, 3'h2} |=> $stable(acc_q)) else $error("dest bad");
  AST_SUB: assert property (
    go && op_sel == 3'h3 |=> acc_q == $past(literal_val) - $past(acc_q)) else $error("sub bad");
  AST_SFLG: assert property (go && op_sel == 3'h3 |=>
    carry_q == ($past(acc_q) <= $past(literal_val)) && zero_q == (acc_q == 8'h00)
    && dc_q == ($past(acc_q[3:0]) <= $past(literal_val[3:0])))
    else $error("flag bad");
  AST_PD: assert property (
    go && op_sel == 3'h4 |=> !sleep_entry_flag_n_q && expiry_status_n_q) else $error("pd bad");
  AST_WDT: assert property (
    go && op_sel == 3'h4 |=> watchdog_counter_q == 8'h00 && prescale_q == 8'h00)
    else $error("wdt bad");
  AST_OSC: assert property (
    go && op_sel == 3'h4 |=> !osc_run_q && !exec_ready) else $error("osc bad");
  AST_HALT: assert property (!exec_ready |=> $stable(acc_q)) else $error("halt bad");
  // Main scenarios reached
  cover property (go && op_sel == 3'h1);
  cover property (go && op_sel == 3'h4);
  cover property ($rose(exec_ready));
endmodule // rsx_exec_chk
bind rsx_exec rsx_exec_chk u_chk (.*);

//--- tb/tb_rsx_exec.sv
`timescale 1ns/10ps
module tb_rsx_exec;
  reg sys_clk = 0, rst_b = 0, op_valid = 0, dest_sel = 0, wdt_tick = 0, wake_req = 0;
  reg [2:0] op_sel = 3'h0;
  reg [6:0] file_addr = 7'h00;
  reg [7:0] literal_val = 8'h00, m = 8'h00, k, r;
  wire [7:0] acc_q, file_rd_data_q, watchdog_counter_q, prescale_q;
  wire carry_q, dc_q, zero_q, sleep_entry_flag_n_q, expiry_status_n_q, osc_run_q, exec_ready;
  integer errors = 0, tests_run = 0, i, j;
  rsx_exec u_rsx_exec (.*);
  // 25 MHz core clock
  always #20 sys_clk = ~sys_clk;
  task chk(input [8:0] s, input [8:0] e); begin
    tests_run = tests_run + 1;
    if (s !== e) begin
      errors = errors + 1;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  end endtask
  task report_and_stop; begin
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  end endtask
  // One operation per edge; idle ends a burst
  task op(input [2:0] s, input [6:0] a, input d, input [7:0] l); begin
    op_valid = 1; op_sel = s; file_addr = a; dest_sel = d; literal_val = l;
    @(posedge sys_clk); #1;
  end endtask
  task idle; begin op_valid = 0; @(posedge sys_clk); #1; end endtask
  task t_sub; begin
    for (j = 0; j < 6; j = j + 1) begin
      k = 48'h0503FE00807F >> (40 - 8 * j);
      r = k - m;
      op(3'h3, 7'h00, 1'h0, k); idle;
      chk(acc_q, r);
      chk({carry_q, dc_q, zero_q}, {m <= k, m[3:0] <= k[3:0], r == 8'h00});
      m = r;
    end
  end endtask
  // Builds a file value by shifting chosen carries in from the top
  task t_rot; begin
    op(3'h3, 7'h7F, 1'h0, 8'hFF);
    for (i = 0; i < 8; i = i + 1) begin
      op(3'h3, 7'h7F, 1'h0, 8'h01);
      if (!i[0] ^ (i == 3)) op(3'h3, 7'h7F, 1'h0, 8'h00);
      op(3'h1, 7'h7F, 1'h1, 8'h00);
      op(3'h3, 7'h7F, 1'h0, (i[0] ^ (i == 3)) ? 8'h01 : 8'hFF);
    end
    idle; idle;
    chk(file_rd_data_q, 8'hA2);
    op(3'h1, 7'h7F, 1'h0, 8'h00); idle;
    chk({carry_q, acc_q}, 9'h0D1);
    op(3'h2, 7'h7F, 1'h0, 8'h00); idle;
    chk({carry_q, acc_q}, 9'h144);
    op(3'h2, 7'h7F, 1'h1, 8'h00); idle; idle;
    chk(file_rd_data_q, 8'h45);
    chk(acc_q, 8'h44);
  end endtask
  task t_sleep; begin
    wdt_tick = 1;
    repeat (300) @(posedge sys_clk);
    #1 op(3'h4, 7'h00, 1'h0, 8'h00);
    chk({sleep_entry_flag_n_q, expiry_status_n_q}, 2'h1);
    chk(watchdog_counter_q | prescale_q, 8'h00);
    op(3'h3, 7'h00, 1'h0, 8'hFF); idle;
    chk({exec_ready, acc_q}, 9'h044);
    wake_req = 1;
    for (i = 0; i < 10 && exec_ready !== 1'b1; i = i + 1) idle;
    wake_req = 0;
    op(3'h3, 7'h00, 1'h0, 8'h70); idle;
    chk(acc_q, 8'h2C);
  end endtask
  initial begin
    repeat (20) @(posedge sys_clk);
    #1 rst_b = 1;
    t_sub; t_rot; t_sleep;
    report_and_stop;
  end
  // Cuts a hang short
  initial begin #100000; errors = errors + 1; report_and_stop; end
endmodule // tb_rsx_exec
